// *** logic/float_arith_unit.sv ***
// Floating point arithmetic unit: decode, fetch, execute and write-back
//
// Contract
// - First word's top bit is the fraction sign; one means negative.
// - A biased nine-bit exponent follows the sign bit.
// - Fraction is 22 bits single, 38 bits double.
// - Binary point sits left of the fraction's top bit.
// - Single values are two words, double values three words.
// - Even register holds high word, next odd register the low word.
// - Registers used: field, field or 1, and field or 2 for double.
// - Every result written back is normalised.
// - Unnormalised operands come back normalised; zero fraction is exempt.
// - Most significant word sits at lower address or register.
// - Exponent outside nine-bit range flags overflow or underflow.
// - Overflow or underflow raises a trap at level five.
// - Add, subtract, multiply, divide; register or memory; single or double.
// - Single register add writes the sum to destination, about 15 us.
// - Single register subtract writes destination minus source, 15 us.
// - Single register multiply completes in about 12.5 us.
// - Divide by zero divisor signals overflow.
module float_arith_unit (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // Instruction issue
    input wire logic start_in,
    input wire logic [15:0] instr_in,
    input wire logic [15:0] ea_in,
    // Status
    output logic busy_out,
    output logic done_out,
    output logic trap_req_out,
    output logic [2:0] trap_level_out,
    // Register file read
    output logic [3:0] reg_rd_idx_out,
    input wire logic [15:0] reg_rd_data_in,
    // Register file write
    output logic reg_wr_en_out,
    output logic [3:0] reg_wr_idx_out,
    output logic [15:0] reg_wr_data_out,
    // Memory read
    output logic mem_rd_req_out,
    output logic [15:0] mem_addr_out,
    input wire logic [15:0] mem_data_in,
    input wire logic mem_ack_in
);
    fpu_pkg::fsm_state_type state_q;
    fpu_pkg::arith_op_type op;
    logic [3:0] sel_q, dest_q, src_q;
    logic [15:0] ea_q;
    logic [5:0][15:0] opw_q;
    logic [2:0] idx_q, nw, src_j, slot;
    logic [11:0] tmr_q, cyc_q;
    logic [38:0] rem_q;
    logic [5:0] dcnt_q;
    logic signed [11:0] n_exp_q;
    logic [39:0] n_mant_q;
    logic dz_q, n_sign_q, q_bit, dbl, mem_form, in_dest;
    logic fetch_ok, fetch_last, accept, time_up, fail;
    fpu_norm_if nif ();
    fpu_normalizer u_norm (
        .nif(nif.norm)
    );

    // ----------------------------------------------------------------
    // Decode and fetch steering
    // ----------------------------------------------------------------
    assign accept = start_in && (state_q == fpu_pkg::ST_IDLE) &&
        (instr_in[fpu_pkg::MAJOR_HI:fpu_pkg::MAJOR_LO] ==
         fpu_pkg::MAJOR_FLOAT);
    assign op = fpu_pkg::arith_op_type'(sel_q[1:0]);
    assign dbl = sel_q[fpu_pkg::SEL_DBL_BIT];
    assign mem_form = sel_q[fpu_pkg::SEL_MEM_BIT];
    assign nw = dbl ? 3'h3 : 3'h2;
    assign in_dest = idx_q < nw;
    assign src_j = idx_q - nw;
    assign slot = in_dest ? idx_q : 3'(fpu_pkg::SRC_SLOT) + src_j;
    assign fetch_ok = in_dest || !mem_form || mem_ack_in;
    assign fetch_last = (idx_q == 3'((nw << 1) - 3'h1));
    assign time_up = tmr_q >= cyc_q;
    assign fail = nif.ovf || dz_q;
    assign reg_rd_idx_out = (state_q == fpu_pkg::ST_WRITE || in_dest) ?
        fpu_pkg::reg_sel(dest_q, idx_q[1:0]) :
        fpu_pkg::reg_sel(src_q, src_j[1:0]);
    assign mem_rd_req_out = (state_q == fpu_pkg::ST_FETCH) && !in_dest &&
        mem_form;
    assign mem_addr_out = ea_q + {13'h0000, src_j};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= fpu_pkg::ST_IDLE;
        end
        else
        begin
            unique case (state_q)
                fpu_pkg::ST_IDLE:
                    if (accept)
                    begin
                        state_q <= fpu_pkg::ST_FETCH;
                    end
                fpu_pkg::ST_FETCH:
                    if (fetch_ok && fetch_last)
                    begin
                        state_q <= fpu_pkg::ST_EXEC;
                    end
                fpu_pkg::ST_EXEC:
                    state_q <= (op == fpu_pkg::OP_DIV) ? fpu_pkg::ST_DIV :
                        fpu_pkg::ST_WAIT;
                fpu_pkg::ST_DIV:
                    if (dcnt_q == 6'h01)
                    begin
                        state_q <= fpu_pkg::ST_WAIT;
                    end
                fpu_pkg::ST_WAIT:
                    if (time_up)
                    begin
                        state_q <= fail ? fpu_pkg::ST_IDLE :
                            fpu_pkg::ST_WRITE;
                    end
                fpu_pkg::ST_WRITE:
                    if (idx_q == nw - 3'h1)
                    begin
                        state_q <= fpu_pkg::ST_IDLE;
                    end
                default:
                    state_q <= fpu_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Instruction latch and word counter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sel_q <= 4'h0;
            dest_q <= 4'h0;
            src_q <= 4'h0;
            ea_q <= 16'h0000;
            cyc_q <= 12'h000;
        end
        else if (accept)
        begin
            sel_q <= instr_in[fpu_pkg::SEL_HI:fpu_pkg::SEL_LO];
            dest_q <= instr_in[fpu_pkg::DEST_HI:fpu_pkg::DEST_LO];
            src_q <= instr_in[fpu_pkg::SRC_HI:fpu_pkg::SRC_LO];
            ea_q <= ea_in;
            cyc_q <= fpu_pkg::op_cycles(
                instr_in[fpu_pkg::SEL_HI:fpu_pkg::SEL_LO]);
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            idx_q <= 3'h0;
        end
        else if (state_q == fpu_pkg::ST_WRITE ||
            (state_q == fpu_pkg::ST_FETCH && fetch_ok && !fetch_last))
        begin
            idx_q <= idx_q + 3'h1;
        end
        else if (state_q != fpu_pkg::ST_FETCH || fetch_ok)
        begin
            idx_q <= 3'h0;
        end
    end

    // Elapsed cycles since issue, saturating
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tmr_q <= 12'h000;
        end
        else if (accept)
        begin
            tmr_q <= 12'h001;
        end
        else if (tmr_q != 12'hFFF)
        begin
            tmr_q <= tmr_q + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Operand capture
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            opw_q <= '0;
        end
        else if (accept)
        begin
            opw_q <= '0;
        end
        else if (state_q == fpu_pkg::ST_FETCH && fetch_ok)
        begin
            opw_q[slot] <= (!in_dest && mem_form) ? mem_data_in :
                reg_rd_data_in;
        end
    end

    // ----------------------------------------------------------------
    // Execute: add, subtract, multiply, divide setup
    // ----------------------------------------------------------------
    logic [37:0] fa, fb;
    logic signed [11:0] ea, eb, x_exp;
    logic sa, sb, a_big, x_sign;
    logic [11:0] diff;
    logic [39:0] mb, ms, x_mant;
    logic [75:0] prod;

    always_comb
    begin
        fa = fpu_pkg::frac_of(opw_q[0], opw_q[1], opw_q[2], dbl);
        fb = fpu_pkg::frac_of(opw_q[3], opw_q[4], opw_q[5], dbl);
        ea = fpu_pkg::exp_of(opw_q[0]);
        eb = fpu_pkg::exp_of(opw_q[3]);
        sa = opw_q[0][fpu_pkg::SIGN_BIT];
        sb = opw_q[3][fpu_pkg::SIGN_BIT] ^ (op == fpu_pkg::OP_SUB);
        a_big = (fb == 38'h0) || (fa != 38'h0 && ea >= eb);
        diff = a_big ? 12'(ea - eb) : 12'(eb - ea);
        mb = a_big ? {1'b0, fa, 1'b0} : {1'b0, fb, 1'b0};
        ms = (a_big ? {1'b0, fb, 1'b0} : {1'b0, fa, 1'b0}) >> diff;
        prod = fa * fb;
        x_sign = a_big ? sa : sb;
        x_exp = a_big ? ea : eb;
        x_mant = mb + ms;
        unique case (op)
            fpu_pkg::OP_ADD, fpu_pkg::OP_SUB:
                if (sa != sb)
                begin
                    x_mant = (mb >= ms) ? mb - ms : ms - mb;
                    x_sign = x_sign ^ (ms > mb);
                end
            fpu_pkg::OP_MUL:
            begin
                x_sign = sa ^ sb;
                x_exp = ea + eb - fpu_pkg::EXP_BIAS;
                x_mant = {1'b0, prod[75:37]};
            end
            fpu_pkg::OP_DIV:
            begin
                x_sign = sa ^ sb;
                x_exp = ea - eb + fpu_pkg::EXP_BIAS;
                x_mant = 40'h00_0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Raw result and restoring divider
    // ----------------------------------------------------------------
    assign q_bit = rem_q >= {1'b0, fb};
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            n_sign_q <= 1'b0;
            n_exp_q <= 12'sh000;
            n_mant_q <= 40'h00_0000_0000;
            rem_q <= 39'h0;
            dcnt_q <= 6'h00;
            dz_q <= 1'b0;
        end
        else if (state_q == fpu_pkg::ST_EXEC)
        begin
            n_sign_q <= x_sign;
            n_exp_q <= x_exp;
            n_mant_q <= x_mant;
            rem_q <= {1'b0, fa};
            dcnt_q <= 6'(fpu_pkg::MANT_W);
            dz_q <= (op == fpu_pkg::OP_DIV) && (fb == 38'h0);
        end
        else if (state_q == fpu_pkg::ST_DIV)
        begin
            dcnt_q <= dcnt_q - 6'h01;
            rem_q <= 39'((q_bit ? rem_q - {1'b0, fb} : rem_q) << 1);
            n_mant_q <= {n_mant_q[38:0], q_bit};
        end
    end

    assign nif.sign = n_sign_q;
    assign nif.exp = n_exp_q;
    assign nif.mant = n_mant_q;
    assign nif.dbl = dbl;

    // ----------------------------------------------------------------
    // Write-back, completion and trap
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reg_wr_en_out <= 1'b0;
            reg_wr_idx_out <= 4'h0;
            reg_wr_data_out <= 16'h0000;
            done_out <= 1'b0;
            trap_req_out <= 1'b0;
        end
        else
        begin
            reg_wr_en_out <= (state_q == fpu_pkg::ST_WRITE);
            reg_wr_idx_out <= fpu_pkg::reg_sel(dest_q, idx_q[1:0]);
            reg_wr_data_out <= nif.word[idx_q[1:0]];
            done_out <= (state_q == fpu_pkg::ST_WRITE &&
                idx_q == nw - 3'h1) ||
                (state_q == fpu_pkg::ST_WAIT && time_up && fail);
            trap_req_out <= state_q == fpu_pkg::ST_WAIT && time_up &&
                fail;
        end
    end
    assign busy_out = (state_q != fpu_pkg::ST_IDLE);
    assign trap_level_out = fpu_pkg::TRAP_LEVEL;
endmodule

// *** logic/fpu_pkg.sv ***
// Constants, types and helpers shared by the floating point unit
package fpu_pkg;

    // ----------------------------------------------------------------
    // Number format
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned FRAC_W = 38;
    localparam int unsigned MANT_W = 40;
    localparam int unsigned SIGN_BIT = 15;
    localparam int unsigned EXP_HI = 14;
    localparam int unsigned EXP_LO = 6;
    localparam logic signed [11:0] EXP_BIAS = 12'sh100;
    localparam logic signed [11:0] EXP_MAX = 12'sh1FF;

    // ----------------------------------------------------------------
    // Instruction word fields
    // ----------------------------------------------------------------
    localparam logic [3:0] MAJOR_FLOAT = 4'h3;
    localparam int unsigned MAJOR_HI = 15;
    localparam int unsigned MAJOR_LO = 12;
    localparam int unsigned SEL_HI = 11;
    localparam int unsigned SEL_LO = 8;
    localparam int unsigned DEST_HI = 7;
    localparam int unsigned DEST_LO = 4;
    localparam int unsigned SRC_HI = 3;
    localparam int unsigned SRC_LO = 0;
    localparam int unsigned SEL_MEM_BIT = 3;
    localparam int unsigned SEL_DBL_BIT = 2;
    localparam int unsigned SRC_SLOT = 3;

    // ----------------------------------------------------------------
    // Trap and timing
    // ----------------------------------------------------------------
    localparam logic [2:0] TRAP_LEVEL = 3'h5;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // Execution time per selector code, in ns
    localparam int unsigned OP_TIME_NS [16] = '{
        15000, 15000, 12500, 15500,
        20500, 20500, 16000, 16500,
        17500, 17500, 14500, 15500,
        22500, 22500, 18000, 18500
    };

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_ADD = 2'h0,
        OP_SUB = 2'h1,
        OP_MUL = 2'h2,
        OP_DIV = 2'h3
    } arith_op_type;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FETCH = 6'h02,
        ST_EXEC = 6'h04,
        ST_DIV = 6'h08,
        ST_WAIT = 6'h10,
        ST_WRITE = 6'h20
    } fsm_state_type;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] reg_sel(input logic [3:0] field,
                                           input logic [1:0] k);
        reg_sel = field | {2'h0, k};
    endfunction

    function automatic logic [FRAC_W-1:0] frac_of(
        input logic [WORD_W-1:0] w0,
        input logic [WORD_W-1:0] w1,
        input logic [WORD_W-1:0] w2,
        input logic dbl);
        frac_of = {w0[EXP_LO-1:0], w1, (dbl ? w2 : 16'h0000)};
    endfunction

    function automatic logic signed [11:0] exp_of(
        input logic [WORD_W-1:0] w0);
        exp_of = $signed({3'h0, w0[EXP_HI:EXP_LO]});
    endfunction

    function automatic logic [11:0] op_cycles(input logic [3:0] sel);
        op_cycles = 12'(OP_TIME_NS[sel] / CLK_PERIOD_NS);
    endfunction

endpackage

// *** logic/fpu_norm_if.sv ***
// Carrier between the sequencer and the result normaliser
interface fpu_norm_if;
    logic sign;
    logic signed [11:0] exp;
    logic [39:0] mant;
    logic dbl;
    logic [2:0][15:0] word;
    logic ovf;

    modport core(output sign, output exp, output mant, output dbl,
                 input word, input ovf);
    modport norm(input sign, input exp, input mant, input dbl,
                 output word, output ovf);
endinterface

// *** logic/fpu_normalizer.sv ***
// Normalises a raw result and packs it into register words
module fpu_normalizer (
    fpu_norm_if.norm nif
);
    logic [5:0] lz;
    logic found;
    logic [39:0] m;
    logic signed [11:0] e;
    logic zero;
    logic [37:0] frac;

    // ----------------------------------------------------------------
    // Leading zero count
    // ----------------------------------------------------------------
    always_comb
    begin
        lz = 6'h00;
        found = 1'b0;
        for (int i = 38; i >= 0; i--)
        begin
            if (!found && nif.mant[i])
            begin
                found = 1'b1;
                lz = 6'(38 - i);
            end
        end
    end

    // ----------------------------------------------------------------
    // Shift, range check and pack
    // ----------------------------------------------------------------
    always_comb
    begin
        zero = (nif.mant == 40'h00_0000_0000);
        if (nif.mant[39])
        begin
            m = nif.mant >> 1;
            e = nif.exp + 12'sh001;
        end
        else
        begin
            m = nif.mant << lz;
            e = nif.exp - $signed({6'h00, lz});
        end
        frac = m[38:1];
        nif.ovf = !zero && (e < 12'sh000 || e > fpu_pkg::EXP_MAX);
        if (zero)
        begin
            nif.word = '0;
        end
        else
        begin
            nif.word[0] = {nif.sign, e[8:0], frac[37:32]};
            nif.word[1] = frac[31:16];
            nif.word[2] = nif.dbl ? frac[15:0] : 16'h0000;
        end
    end
endmodule

// *** logic/fpu_timing_note.sv ***
// Holds no logic: all timing counts live in the unit's package

// *** tb/fau_properties.sv ***
// Port checks for the floating point unit
module fau_properties (
    // Inputs
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic [15:0] instr_in,
    input wire logic [15:0] ea_in,
    input wire logic mem_ack_in,
    // Outputs
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic trap_req_out,
    input wire logic [2:0] trap_level_out,
    input wire logic reg_wr_en_out,
    input wire logic [3:0] reg_wr_idx_out,
    input wire logic [15:0] reg_wr_data_out,
    input wire logic mem_rd_req_out,
    input wire logic [15:0] mem_addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Tracking
    // ----
    logic acc;
    logic [3:0] dst_q;
    logic [3:0] sel_q;
    logic [15:0] ea_q;
    logic [11:0] cnt_q;
    logic [1:0] wn_q;
    logic wrote_q;
    int cyc;
    assign acc = start_in && !busy_out
        && instr_in[15:12] == fpu_pkg::MAJOR_FLOAT;
    assign cyc = fpu_pkg::OP_TIME_NS[sel_q] / 20;
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cnt_q <= 12'h000;
            wn_q <= 2'h0;
            wrote_q <= 1'b0;
            dst_q <= 4'h0;
            sel_q <= 4'h0;
            ea_q <= 16'h0000;
        end
        else if (acc)
        begin
            cnt_q <= 12'h001;
            wn_q <= 2'h0;
            wrote_q <= 1'b0;
            dst_q <= instr_in[7:4];
            sel_q <= instr_in[11:8];
            ea_q <= ea_in;
        end
        else
        begin
            cnt_q <= cnt_q + 12'h001;
            wn_q <= wn_q + {1'b0, reg_wr_en_out};
            wrote_q <= wrote_q || reg_wr_en_out;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence s_acc;
        acc;
    endsequence
    sequence s_run;
        busy_out [*8];
    endsequence
    property p_busy;
        s_acc |=> s_run;
    endproperty
    property p_level;
        trap_level_out == fpu_pkg::TRAP_LEVEL;
    endproperty
    property p_trap;
        trap_req_out |-> done_out && !wrote_q && !reg_wr_en_out;
    endproperty
    property p_widx;
        reg_wr_en_out |-> reg_wr_idx_out == (dst_q | {2'h0, wn_q});
    endproperty
    property p_wcnt;
        done_out && !trap_req_out
            |-> reg_wr_en_out && wn_q == (sel_q[2] ? 2'h2 : 2'h1);
    endproperty
    property p_norm;
        reg_wr_en_out && wn_q == 2'h0
            |-> reg_wr_data_out[5] || reg_wr_data_out == 16'h0000;
    endproperty
    property p_time;
        done_out |-> cnt_q + 4 >= cyc && cnt_q <= cyc + 200;
    endproperty
    property p_mhold;
        mem_rd_req_out && !mem_ack_in
            |=> mem_rd_req_out && $stable(mem_addr_out);
    endproperty
    property p_maddr;
        mem_rd_req_out |-> 16'(mem_addr_out - ea_q) < 16'h0003;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low");
    a_level: assert property (p_level) else $error("level");
    a_trap: assert property (p_trap) else $error("trap");
    a_widx: assert property (p_widx) else $error("widx");
    a_wcnt: assert property (p_wcnt) else $error("wcnt");
    a_norm: assert property (p_norm) else $error("norm");
    a_time: assert property (p_time) else $error("time");
    a_mhold: assert property (p_mhold) else $error("hold");
    a_maddr: assert property (p_maddr) else $error("addr");
endmodule

bind float_arith_unit fau_properties chk (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .start_in(start_in),
    .instr_in(instr_in),
    .ea_in(ea_in),
    .mem_ack_in(mem_ack_in),
    .busy_out(busy_out),
    .done_out(done_out),
    .trap_req_out(trap_req_out),
    .trap_level_out(trap_level_out),
    .reg_wr_en_out(reg_wr_en_out),
    .reg_wr_idx_out(reg_wr_idx_out),
    .reg_wr_data_out(reg_wr_data_out),
    .mem_rd_req_out(mem_rd_req_out),
    .mem_addr_out(mem_addr_out)
);

// *** tb/fau_cpu_model.sv ***
// Register file and memory beside the floating point unit
module fau_cpu_model (
    // Clock and register file
    input wire logic clk_in,
    input wire logic [3:0] rd_idx_in,
    output logic [15:0] rd_data_out,
    input wire logic wr_en_in,
    input wire logic [3:0] wr_idx_in,
    input wire logic [15:0] wr_data_in,
    // Memory
    input wire logic req_in,
    input wire logic [15:0] addr_in,
    output logic [15:0] data_out,
    output logic ack_out = 1'b0,
    input wire logic slow_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] regs [16];
    logic [15:0] mem [256];
    logic [15:0] last_q = 16'h0000;
    int wait_q = 0;
    assign rd_data_out = regs[rd_idx_in];
    always @(posedge clk_in)
    begin
        if (wr_en_in)
            regs[wr_idx_in] <= wr_data_in;
    end
    // Data line shows no stale value outside an answer
    always @(posedge clk_in)
    begin
        ack_out <= 1'b0;
        data_out <= ~last_q;
        wait_q <= (req_in && !ack_out) ? wait_q + 1 : 0;
        if (req_in && !ack_out && wait_q >= (slow_in ? 3 : 0))
        begin
            ack_out <= 1'b1;
            data_out <= mem[addr_in[7:0]];
            last_q <= mem[addr_in[7:0]];
        end
    end
endmodule

// *** tb/tb_float_arith_unit.sv ***
// Self-checking bench for the floating point unit
module tb_float_arith_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic start_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [15:0] ea_in = 16'h0000;
    logic slow = 1'b0;
    logic busy_out, done_out, trap_req_out, reg_wr_en_out;
    logic mem_rd_req_out, mem_ack_in;
    logic [2:0] trap_level_out;
    logic [3:0] reg_rd_idx_out, reg_wr_idx_out;
    logic [15:0] reg_rd_data_in, reg_wr_data_out;
    logic [15:0] mem_addr_out, mem_data_in;
    logic [15:0] rnd = 16'h13D3;
    logic [47:0] a_w, b_w;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    float_arith_unit DUT (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .start_in(start_in),
        .instr_in(instr_in),
        .ea_in(ea_in),
        .busy_out(busy_out),
        .done_out(done_out),
        .trap_req_out(trap_req_out),
        .trap_level_out(trap_level_out),
        .reg_rd_idx_out(reg_rd_idx_out),
        .reg_rd_data_in(reg_rd_data_in),
        .reg_wr_en_out(reg_wr_en_out),
        .reg_wr_idx_out(reg_wr_idx_out),
        .reg_wr_data_out(reg_wr_data_out),
        .mem_rd_req_out(mem_rd_req_out),
        .mem_addr_out(mem_addr_out),
        .mem_data_in(mem_data_in),
        .mem_ack_in(mem_ack_in)
    );
    fau_cpu_model P (
        .clk_in(ref_clk_in),
        .rd_idx_in(reg_rd_idx_out),
        .rd_data_out(reg_rd_data_in),
        .wr_en_in(reg_wr_en_out),
        .wr_idx_in(reg_wr_idx_out),
        .wr_data_in(reg_wr_data_out),
        .req_in(mem_rd_req_out),
        .addr_in(mem_addr_out),
        .data_out(mem_data_in),
        .ack_out(mem_ack_in),
        .slow_in(slow)
    );
    initial
    begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // ----
    // Helpers
    // ----
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [48:0] fmodel(input logic [3:0] op,
        input logic [47:0] a, input logic [47:0] b);
        logic [79:0] fa, fb, r;
        int ea, eb;
        logic s, sb;
        fa = 80'({a[37:16], op[2] ? a[15:0] : 16'h0000});
        fb = 80'({b[37:16], op[2] ? b[15:0] : 16'h0000});
        ea = int'(a[46:38]);
        eb = int'(b[46:38]);
        sb = b[47] ^ (op[1:0] == 2'h1);
        if (op[1:0] == 2'h3 && fb == 0)
            return {1'b1, a};
        if (op[1])
        begin
            r = op[0] ? (fa << 38) / fb : (fa * fb) >> 38;
            ea = op[0] ? ea - eb + 256 : ea + eb - 256;
            s = a[47] ^ b[47];
        end
        else
        begin
            fa = fa >> (ea < eb ? eb - ea : 0);
            fb = fb >> (eb < ea ? ea - eb : 0);
            ea = ea < eb ? eb : ea;
            r = (a[47] == sb) ? fa + fb : (fa >= fb ? fa - fb : fb - fa);
            s = (a[47] != sb && fb > fa) ? sb : a[47];
        end
        if (r == 0)
            return 49'h0;
        for (; r[38]; ea++) r = r >> 1;
        for (; !r[37]; ea--) r = r << 1;
        if (ea < 0 || ea > 511)
            return {1'b1, a};
        return {1'b0, s, 9'(ea), r[37:0]};
    endfunction
    task automatic run(input logic [15:0] ins, input logic [15:0] ea,
        input logic [47:0] a, input logic [47:0] b);
        logic [48:0] e;
        int n;
        int k;
        int c;
        e = fmodel(ins[11:8], a, b);
        n = ins[10] ? 3 : 2;
        c = fpu_pkg::OP_TIME_NS[ins[11:8]] / 20;
        for (int i = 0; i < n; i++)
        begin
            P.regs[ins[7:4] | 4'(i)] = a[47-16*i -: 16];
            P.regs[ins[3:0] | 4'(i)] = b[47-16*i -: 16];
            P.mem[ea[7:0] + 8'(i)] = b[47-16*i -: 16];
        end
        @(negedge ref_clk_in);
        start_in = 1'b1;
        instr_in = ins;
        ea_in = ea;
        @(negedge ref_clk_in);
        start_in = 1'b0;
        check(busy_out, 1'b1);
        k = 1;
        while (done_out !== 1'b1 && k < 3000)
        begin
            start_in = (k == 40);
            instr_in = (k == 40) ? 16'h30EE : ins;
            @(negedge ref_clk_in);
            k++;
        end
        check(done_out, 1'b1);
        check(trap_req_out, e[48]);
        check(k + 4 >= c && k <= c + 40, 1'b1);
        @(negedge ref_clk_in);
        for (int i = 0; i < n; i++)
            check(P.regs[ins[7:4] | 4'(i)], e[47-16*i -: 16]);
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        for (int i = 0; i < 16; i++)
            P.regs[i] = 16'hAAAA;
        repeat (20) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        start_in = 1'b1;
        instr_in = 16'h2002;
        @(negedge ref_clk_in);
        start_in = 1'b0;
        check(busy_out, 1'b0);
        run(16'h3002, 16'h0000, {16'h4060, 32'h0}, {16'h4060, 32'h0});
        run(16'h3146, 16'h0000, {16'h0030, 32'h0}, {16'h0020, 32'h0});
        run(16'h3002, 16'h0000, {16'h7FE0, 32'h0}, {16'h7FE0, 32'h0});
        run(16'h3224, 16'h0000, {16'h4060, 32'h0}, {16'h40B0, 32'h0});
        run(16'h3302, 16'h0000, {16'h4060, 32'h0}, 48'h0);
        run(16'h3068, 16'h0000, 48'h0, {16'h4142, 32'h0});
        run(16'h3448, 16'h0000, 48'h4060_0001_8000, 48'hC050_0000_0001);
        slow = 1'b1;
        run(16'h3826, 16'h0040, {16'h4060, 32'h0}, {16'h40B0, 32'h0});
        repeat (8)
        begin
            rnd = lfsr(rnd);
            a_w = {rnd[15], 9'(254 + rnd[6:4]), 1'b1, rnd[11:7], 32'h0};
            rnd = lfsr(rnd);
            b_w = {rnd[15], 9'(254 + rnd[6:4]), 1'b1, rnd[11:7], 32'h0};
            slow = rnd[0];
            run({4'h3, rnd[3:0], 8'h48}, {10'h0, rnd[13:8]}, a_w, b_w);
        end
        check(P.regs[14], 16'hAAAA);
        finish_test();
    end
endmodule
